//--- dv/rtcis_sva.sv
// assertions watching the two-wire link between controller and target
`timescale 1ns/1ps
`include "rtcis_defs.svh"
module rtcis_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_r, sda_r, frm_r, first_r, hit_r, rw_r;
  logic [3:0] cnt_r, hold_r;
  logic [7:0] sh_r;
  wire        start = scl && scl_r && sda_r && !sda;
  wire        stop = scl && scl_r && !sda_r && sda;
  wire        rise = scl && !scl_r;
  wire        slot9 = frm_r && rise && cnt_r == 4'h8;
  wire        amatch = sh_r[7:1] == `RTCIS_TGT_ADDR;
  wire        rd_slot = slot9 && !first_r && hit_r && rw_r;
  always_ff @(posedge ref_clk) begin
    scl_r <= scl;
    sda_r <= sda;
    frm_r <= !rst && !stop && (frm_r || start);
    first_r <= start || (first_r && !slot9);
    hit_r <= !start && (slot9 && first_r ? amatch : hit_r);
    if (slot9 && first_r)
      rw_r <= sh_r[0];
    if (rise && cnt_r < 4'h8)
      sh_r <= {sh_r[6:0], sda};
  end
  // bit slots counted mod 9 from each start; hold counts rises under a target low
  always_ff @(posedge ref_clk) begin
    if (start)
      cnt_r <= 4'h0;
    else if (rise)
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
    if (!tgt_sda_oe)
      hold_r <= 4'h0;
    else if (rise && hold_r != 4'hF)
      hold_r <= hold_r + 4'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_ack_rise;
    slot9 && tgt_sda_oe;
  endsequence
  sequence s_low_held;
    (!sda && tgt_sda_oe) [*6];
  endsequence
  chk_addr_ack: assert property (slot9 && first_r && amatch |-> tgt_sda_oe)
    else $error("own address not acked");
  chk_addr_miss: assert property (slot9 && first_r && !amatch |-> !tgt_sda_oe)
    else $error("foreign address acked");
  chk_miss_quiet: assert property (frm_r && !first_r && !hit_r |-> !tgt_sda_oe)
    else $error("sda driven after miss");
  chk_wr_ack: assert property (slot9 && !first_r && hit_r && !rw_r |-> tgt_sda_oe)
    else $error("write byte not acked");
  chk_ack_held: assert property (s_ack_rise |-> s_low_held)
    else $error("ack not held low");
  chk_rd_free: assert property (rd_slot |-> !tgt_sda_oe)
    else $error("target drove read ack slot");
  chk_rd_release: assert property (rd_slot && sda |=> !tgt_sda_oe [*8])
    else $error("sda not released after nack");
  chk_tgt_still: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target sda moved with scl high");
  chk_start_form: assert property (start |-> ##[1:12] !scl)
    else $error("start not followed by scl low");
  chk_stop_idle: assert property (stop |-> (scl && sda && !tgt_sda_oe) [*3])
    else $error("bus not idle after stop");
  // ack slot plus an all-zero read byte is nine held rises, the legal worst case
  chk_hold_bound: assert property (hold_r <= 4'h9)
    else $error("target held sda past a byte");
endmodule

//--- dv/rtcis_tb_top.sv
// bench: controller and target joined on the link, random traffic plus corners
`timescale 1ns/1ps
`include "rtcis_defs.svh"
module rtcis_tb_top;
  localparam logic [6:0] TA = `RTCIS_TGT_ADDR;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_last = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic       cmd_ready, rsp_valid, rsp_ack, reg_wr, reg_rd, addressed, got, ak;
  logic [7:0] rsp_data, reg_rdata, reg_wdata, rd;
  logic [4:0] reg_raddr, reg_waddr, p;
  logic [7:0] mem [32];
  logic [7:0] exp_m [32];
  logic [6:0] bad [4] = '{7'h50, 7'h11, 7'h28, 7'h53};
  int         miscompares = 0;
  int         n_checks = 0;
  int         n_rsp = 0;
  int         n_rd = 0;
  int         n;
  rtcis_if u_if ();
  rtcis_ctrl i_rtcis_ctrl (.ref_clk(ref_clk), .rst(rst), .bus(u_if.ctrl),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  rtcis_target i_rtcis_target (.ref_clk(ref_clk), .rst(rst), .bus(u_if.target),
    .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .addressed(addressed));
  rtcis_sva u_chk (.ref_clk(ref_clk), .rst(rst), .tgt_sda_oe(u_if.tgt_sda_oe),
    .scl(u_if.scl), .sda(u_if.sda));
  assign reg_rdata = mem[reg_raddr];
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1)
      mem[reg_waddr] <= reg_wdata;
    if (rsp_valid === 1'b1) begin
      n_rsp <= n_rsp + 1;
      rd <= rsp_data;
      ak <= rsp_ack;
    end
    if (reg_rd === 1'b1)
      n_rd <= n_rd + 1;
  end
  function automatic logic [4:0] nxt(input logic [4:0] q);
    return q + 5'h01;
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic ack_is(input logic e);
    cmp({6'h00, got, ak}, {6'h00, 1'b1, e});
  endtask
  // ready is idle-level, so the command is taken at the edge after valid rises
  task automatic do_cmd(input logic [2:0] op, input logic [7:0] d, input logic l);
    int w;
    int r0;
    w = 0;
    r0 = n_rsp;
    @(posedge ref_clk);
    cmd_op <= op;
    cmd_data <= d;
    cmd_last <= l;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      w++;
    end while (cmd_ready !== 1'b1 && w < 3000);
    if (w >= 3000) begin
      miscompares++;
      print_verdict();
    end else begin
      repeat (2) @(negedge ref_clk);
      got = (n_rsp != r0);
    end
  endtask
  task automatic wr_burst(input logic [4:0] q, input int k, input logic rs);
    logic [7:0] b;
    do_cmd(rtcis_pkg::OP_START, {TA, 1'b0}, 1'b0);
    ack_is(1'b1);
    cmp({7'h00, addressed}, 8'h01);
    do_cmd(rtcis_pkg::OP_WRITE, {3'($urandom), q}, 1'b0);
    ack_is(1'b1);
    for (int i = 0; i < k; i++) begin
      b = 8'($urandom);
      exp_m[q] = b;
      do_cmd(rtcis_pkg::OP_WRITE, b, 1'b0);
      ack_is(1'b1);
      q = nxt(q);
    end
    if (!rs)
      do_cmd(rtcis_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic rd_burst(input logic [4:0] q, input int k, input logic fin);
    int r0;
    r0 = n_rd;
    do_cmd(rtcis_pkg::OP_START, {TA, 1'b0}, 1'b0);
    ack_is(1'b1);
    do_cmd(rtcis_pkg::OP_WRITE, {3'($urandom), q}, 1'b0);
    do_cmd(rtcis_pkg::OP_START, {TA, 1'b1}, 1'b0);
    ack_is(1'b1);
    for (int i = 0; i < k; i++) begin
      do_cmd(rtcis_pkg::OP_READ, 8'h00, fin && i == k - 1);
      cmp(got ? rd : ~exp_m[q], exp_m[q]);
      ack_is(!(fin && i == k - 1));
      q = nxt(q);
    end
    // an acked last byte makes the target fetch once more after the ack slot
    if (!fin)
      repeat (6) @(negedge ref_clk);
    cmp(8'(n_rd - r0), fin ? 8'(k) : 8'(k + 1));
  endtask
  initial begin
    void'($urandom(3350));
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'h00;
      exp_m[i] = 8'h00;
    end
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    // pointer wrap from 30 through 1
    wr_burst(5'h1E, 4, 1'b1);
    rd_burst(5'h1E, 4, 1'b1);
    cmp({7'h00, addressed}, 8'h00);
    for (int j = 0; j < 6; j++) begin
      p = 5'($urandom);
      n = 1 + int'($urandom % 5);
      wr_burst(p, n, j[0]);
      rd_burst(p, n, 1'b1);
    end
    for (int j = 0; j < 8; j++) begin
      do_cmd(rtcis_pkg::OP_START, {bad[j[1:0]], j[2]}, 1'b0);
      ack_is(1'b0);
      do_cmd(rtcis_pkg::OP_WRITE, 8'($urandom), 1'b0);
      ack_is(1'b0);
      cmp({7'h00, addressed}, 8'h00);
      do_cmd(rtcis_pkg::OP_STOP, 8'h00, 1'b0);
    end
    // next byte starts with a zero bit, so the target holds sda low
    mem[5'h10] = 8'hC3;
    exp_m[5'h10] = 8'hC3;
    mem[5'h11] = 8'h00;
    exp_m[5'h11] = 8'h00;
    rd_burst(5'h10, 1, 1'b0);
    repeat (8) @(negedge ref_clk);
    cmp({7'h00, u_if.sda}, 8'h00);
    do_cmd(rtcis_pkg::OP_RECOVER, 8'h00, 1'b0);
    cmp({6'h00, u_if.scl, u_if.sda}, 8'h03);
    cmp({7'h00, addressed}, 8'h00);
    do_cmd(rtcis_pkg::OP_RECOVER, 8'h00, 1'b0);
    cmp({6'h00, u_if.scl, u_if.sda}, 8'h03);
    rd_burst(5'h11, 2, 1'b1);
    print_verdict();
  end
endmodule

//--- hdl/rtcis_ctrl.sv
// serial controller end: start, byte, stop and bus recovery sequencer
`timescale 1ns/1ps
`include "rtcis_defs.svh"
module rtcis_ctrl #(
  parameter int QCYC = `RTCIS_QCYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  rtcis_if.ctrl            bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_last,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_ack
);
  rtcis_pkg::rtcis_cstate_t state_r;
  rtcis_pkg::rtcis_cstate_t st_nxt;
  logic [15:0] div_r;
  logic [1:0]  q_r;
  logic [3:0]  bits_r;
  logic [3:0]  bits_nxt;
  logic [8:0]  sh_r;
  logic [8:0]  sh_nxt;
  logic [8:0]  rx_r;
  logic [8:0]  rx_nxt;
  logic        stop_r;
  logic        stop_nxt;
  logic        scl_oe_r;
  logic        scl_oe_nxt;
  logic        sda_oe_r;
  logic        sda_oe_nxt;
  logic        sda_m;
  logic        sda_s;
  logic        rsp_nxt;

  wire tick   = (div_r == 16'(QCYC - 1));
  wire accept = cmd_valid & cmd_ready;
  wire last_q = (q_r == 2'h3);

  assign cmd_ready      = (state_r == rtcis_pkg::C_IDLE);
  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_r;
  assign bus.ctl_sda_oe = sda_oe_r;

  always_ff @(posedge ref_clk) begin
    sda_m <= bus.sda;
    sda_s <= sda_m;
  end

  always_comb begin
    st_nxt     = state_r;
    bits_nxt   = bits_r;
    sh_nxt     = sh_r;
    rx_nxt     = rx_r;
    stop_nxt   = stop_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rsp_nxt    = 1'b0;
    if (accept) begin
      bits_nxt = 4'h0;
      stop_nxt = 1'b0;
      unique case (cmd_op)
        rtcis_pkg::OP_START: begin
          // the address byte is bundled with every start
          st_nxt = rtcis_pkg::C_START;
          sh_nxt = {cmd_data, 1'b1};
        end
        rtcis_pkg::OP_WRITE: begin
          st_nxt = rtcis_pkg::C_BIT;
          sh_nxt = {cmd_data, 1'b1};
        end
        rtcis_pkg::OP_READ: begin
          st_nxt   = rtcis_pkg::C_BIT;
          sh_nxt   = {8'hFF, cmd_last};
          stop_nxt = cmd_last;
        end
        rtcis_pkg::OP_STOP: begin
          st_nxt = rtcis_pkg::C_STOP;
        end
        rtcis_pkg::OP_RECOVER: begin
          // nine released slots clock out whatever holds sda
          st_nxt   = sda_s ? rtcis_pkg::C_STOP : rtcis_pkg::C_BIT;
          sh_nxt   = 9'h1FF;
          stop_nxt = 1'b1;
        end
        default: begin
          st_nxt = rtcis_pkg::C_IDLE;
        end
      endcase
    end else if (tick) begin
      unique case (state_r)
        rtcis_pkg::C_IDLE: begin
        end
        rtcis_pkg::C_START: begin
          unique case (q_r)
            2'h0: sda_oe_nxt = 1'b0;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b1;
            2'h3: begin
              scl_oe_nxt = 1'b1;
              st_nxt     = rtcis_pkg::C_BIT;
            end
          endcase
        end
        rtcis_pkg::C_BIT: begin
          unique case (q_r)
            2'h0: sda_oe_nxt = ~sh_r[8];
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: rx_nxt = {rx_r[7:0], sda_s};
            2'h3: begin
              scl_oe_nxt = 1'b1;
              sh_nxt     = {sh_r[7:0], 1'b1};
              bits_nxt   = bits_r + 4'h1;
              if (bits_r == `RTCIS_BIT_SLOTS - 4'h1) begin
                rsp_nxt = 1'b1;
                st_nxt  = stop_r ? rtcis_pkg::C_STOP : rtcis_pkg::C_IDLE;
              end
            end
          endcase
        end
        rtcis_pkg::C_STOP: begin
          unique case (q_r)
            2'h0: begin
              scl_oe_nxt = 1'b1;
              sda_oe_nxt = 1'b1;
            end
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b0;
            2'h3: st_nxt = rtcis_pkg::C_IDLE;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r   <= rtcis_pkg::C_IDLE;
      div_r     <= 16'h0000;
      q_r       <= 2'h0;
      bits_r    <= 4'h0;
      sh_r      <= 9'h1FF;
      rx_r      <= 9'h000;
      stop_r    <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_ack   <= 1'b0;
    end else begin
      state_r  <= st_nxt;
      bits_r   <= bits_nxt;
      sh_r     <= sh_nxt;
      rx_r     <= rx_nxt;
      stop_r   <= stop_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      // quarter-bit timebase restarts with every accepted command
      div_r    <= (accept || tick || cmd_ready) ? 16'h0000 : div_r + 16'h0001;
      q_r      <= (accept || cmd_ready) ? 2'h0 : (tick ? q_r + 2'h1 : q_r);
      rsp_valid <= rsp_nxt;
      if (rsp_nxt) begin
        rsp_data <= rx_nxt[8:1];
        rsp_ack  <= ~rx_nxt[0];
      end
    end
  end
endmodule

//--- hdl/rtcis_target.sv
// serial target end: address match, pointer, byte receive and transmit
`timescale 1ns/1ps
`include "rtcis_defs.svh"
module rtcis_target #(
  parameter logic [6:0] ADDR = `RTCIS_TGT_ADDR
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  rtcis_if.target                      bus,
  output logic [`RTCIS_PTR_W-1:0]      reg_raddr,
  input  wire logic [7:0]              reg_rdata,
  output logic                         reg_rd,
  output logic [`RTCIS_PTR_W-1:0]      reg_waddr,
  output logic [7:0]                   reg_wdata,
  output logic                         reg_wr,
  output logic                         addressed
);
  rtcis_pkg::rtcis_tstate_t state_r;
  rtcis_pkg::rtcis_tstate_t st_nxt;
  logic                     scl_m;
  logic                     scl_s;
  logic                     scl_d;
  logic                     sda_m;
  logic                     sda_s;
  logic                     sda_d;
  logic [3:0]               cnt_r;
  logic [3:0]               cnt_nxt;
  logic [7:0]               sh_r;
  logic [7:0]               sh_nxt;
  logic                     oe_r;
  logic                     oe_nxt;
  logic                     rw_r;
  logic                     rw_nxt;
  logic                     first_r;
  logic                     first_nxt;
  logic                     ack_r;
  logic                     ack_nxt;
  logic [`RTCIS_PTR_W-1:0]  ptr_r;
  logic [`RTCIS_PTR_W-1:0]  ptr_nxt;
  logic [`RTCIS_PTR_W-1:0]  waddr_r;
  logic [`RTCIS_PTR_W-1:0]  waddr_nxt;
  logic [7:0]               wdata_r;
  logic [7:0]               wdata_nxt;
  logic                     wr_r;
  logic                     wr_nxt;
  logic                     rd_r;
  logic                     rd_nxt;

  function automatic logic [`RTCIS_PTR_W-1:0] ptr_inc(input logic [`RTCIS_PTR_W-1:0] p);
    return p + 5'h01;
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
    return {s[6:0], b};
  endfunction

  // decoded line events, all from the second sync stage onward
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire cond_high = scl_s & scl_d;
  wire start_ev  = cond_high & sda_d & ~sda_s;
  wire stop_ev   = cond_high & ~sda_d & sda_s;
  wire byte_done = (cnt_r == `RTCIS_BYTE_BITS);
  wire addr_hit  = (sh_r[7:1] == ADDR);
  wire load_rd   = ~start_ev & ~stop_ev & scl_fall &
                   (((state_r == rtcis_pkg::T_AACK) & rw_r) |
                    ((state_r == rtcis_pkg::T_RACK) & ack_r));

  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = oe_r;
  assign reg_raddr      = ptr_r;
  assign reg_rd         = rd_r;
  assign reg_waddr      = waddr_r;
  assign reg_wdata      = wdata_r;
  assign reg_wr         = wr_r;
  assign addressed      = (state_r != rtcis_pkg::T_IDLE) & (state_r != rtcis_pkg::T_ADDR);

  always_ff @(posedge ref_clk) begin
    scl_m <= bus.scl;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= bus.sda;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  always_comb begin
    st_nxt    = state_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    oe_nxt    = oe_r;
    rw_nxt    = rw_r;
    first_nxt = first_r;
    ack_nxt   = ack_r;
    ptr_nxt   = ptr_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    if (start_ev) begin
      // start or repeated start always reopens addressing
      st_nxt  = rtcis_pkg::T_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop_ev) begin
      st_nxt = rtcis_pkg::T_IDLE;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        rtcis_pkg::T_IDLE: begin
          // stray clocks here are ignored until a start
          oe_nxt = 1'b0;
        end
        rtcis_pkg::T_ADDR: begin
          if (scl_rise && !byte_done) begin
            sh_nxt  = shift_in(sh_r, sda_s);
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (addr_hit) begin
              st_nxt = rtcis_pkg::T_AACK;
              oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
            end else begin
              st_nxt = rtcis_pkg::T_IDLE;
            end
          end
        end
        rtcis_pkg::T_AACK: begin
          if (scl_fall && !rw_r) begin
            st_nxt    = rtcis_pkg::T_WR;
            oe_nxt    = 1'b0;
            cnt_nxt   = 4'h0;
            first_nxt = 1'b1;
          end
        end
        rtcis_pkg::T_WR: begin
          if (scl_rise && !byte_done) begin
            sh_nxt  = shift_in(sh_r, sda_s);
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            st_nxt  = rtcis_pkg::T_WACK;
            oe_nxt  = 1'b1;
            cnt_nxt = 4'h0;
            if (first_r) begin
              // upper three pointer bits are dropped
              ptr_nxt   = sh_r[`RTCIS_PTR_W-1:0];
              first_nxt = 1'b0;
            end else begin
              waddr_nxt = ptr_r;
              wdata_nxt = sh_r;
              wr_nxt    = 1'b1;
              ptr_nxt   = ptr_inc(ptr_r);
            end
          end
        end
        rtcis_pkg::T_WACK: begin
          if (scl_fall) begin
            st_nxt = rtcis_pkg::T_WR;
            oe_nxt = 1'b0;
          end
        end
        rtcis_pkg::T_RD: begin
          if (scl_fall) begin
            if (byte_done) begin
              st_nxt = rtcis_pkg::T_RACK;
              oe_nxt = 1'b0; // ack slot belongs to the controller
            end else begin
              sh_nxt  = shift_in(sh_r, 1'b1);
              oe_nxt  = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        rtcis_pkg::T_RACK: begin
          if (scl_rise) begin
            ack_nxt = ~sda_s;
          end else if (scl_fall && !ack_r) begin
            // nack: let go of sda so the controller can stop
            st_nxt = rtcis_pkg::T_IDLE;
            oe_nxt = 1'b0;
          end
        end
      endcase
      if (load_rd) begin
        // pointer survives across transfers, so a read resumes there
        st_nxt  = rtcis_pkg::T_RD;
        sh_nxt  = reg_rdata;
        oe_nxt  = ~reg_rdata[7];
        cnt_nxt = 4'h1;
        rd_nxt  = 1'b1;
        ptr_nxt = ptr_inc(ptr_r);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= rtcis_pkg::T_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      oe_r    <= 1'b0;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      ack_r   <= 1'b0;
      ptr_r   <= `RTCIS_PTR_RST;
      waddr_r <= `RTCIS_PTR_RST;
      wdata_r <= 8'h00;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
    end else begin
      state_r <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      oe_r    <= oe_nxt;
      rw_r    <= rw_nxt;
      first_r <= first_nxt;
      ack_r   <= ack_nxt;
      ptr_r   <= ptr_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
    end
  end
endmodule

//--- inc/rtcis_defs.svh
// constants of the rtc serial target interface and its controller
// Behaviour
// - bytes are eight bits plus acknowledge
// - addressed receiver acknowledges every byte
// - controller acknowledges read bytes except last
// - acknowledger holds sda low while scl high
// - controller ends read with nack, stop
// - target releases sda after nack
// - answer only address 1010001, msb first
// - address byte follows every start
// - address bit 0: 0 write, 1 read
// - write ends by stop or repeated start
// - first write byte sets five-bit pointer
// - read continues from previously written pointer
// - controller clocks nine pulses if sda stuck
// - target returns idle within nine clocks
// - start and stop are sda edges, scl high
// - sda changes only while scl low
`ifndef RTCIS_DEFS_SVH
`define RTCIS_DEFS_SVH
`define RTCIS_TGT_ADDR    7'h51
`define RTCIS_BYTE_BITS   4'h8
`define RTCIS_BIT_SLOTS   4'h9
`define RTCIS_PTR_W       5
`define RTCIS_PTR_RST     5'h00
`define RTCIS_REF_NS      10
`define RTCIS_SCL_NS      160
`define RTCIS_QCYC        (`RTCIS_SCL_NS / (4 * `RTCIS_REF_NS))
`endif

//--- inc/rtcis_if.sv
// two-wire link joining controller and target, open-drain resolved
`timescale 1ns/1ps
interface rtcis_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;
  // pull-ups make the idle level high; any enabled low driver wins
  assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));
  modport ctrl (
    input  scl,
    input  sda,
    output ctl_scl_o,
    output ctl_scl_oe,
    output ctl_sda_o,
    output ctl_sda_oe
  );
  modport target (
    input  scl,
    input  sda,
    output tgt_sda_o,
    output tgt_sda_oe
  );
endinterface

//--- inc/rtcis_pkg.sv
// types shared by both ends of the serial link
package rtcis_pkg;
  typedef enum logic [7:0] {
    T_IDLE = 8'h01,
    T_ADDR = 8'h02,
    T_AACK = 8'h04,
    T_WR   = 8'h08,
    T_WACK = 8'h10,
    T_RD   = 8'h20,
    T_RACK = 8'h40
  } rtcis_tstate_t;
  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_START = 4'h2,
    C_BIT   = 4'h4,
    C_STOP  = 4'h8
  } rtcis_cstate_t;
  typedef enum logic [2:0] {
    OP_START   = 3'h0,
    OP_WRITE   = 3'h1,
    OP_READ    = 3'h2,
    OP_STOP    = 3'h3,
    OP_RECOVER = 3'h4
  } rtcis_op_t;
endpackage
